// [rtl/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
    localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFS_SHARED_CTRL = 8'h08;
    localparam logic [7:0] OFS_RTC_CTRL = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Field positions in irq_control_first.
    localparam int GLOBAL_EN_BIT = 0;
    localparam int DIRECT_EN_LSB = 1;
    localparam int SHARED_EN_BIT = 4;
    localparam int DIRECT_REQ_LSB = 5;

    // Field positions in shared_vector_control and status.
    localparam int MEMBER_EN_LSB = 0;
    localparam int MEMBER_REQ_LSB = 8;
    localparam int STATUS_PEND_BIT = 8;
    localparam int STATUS_FULL_BIT = 9;

    // Source counts and member order: converter, rtc, tick, timer two, peripheral.
    localparam int NUM_DIRECT = 3;
    localparam int NUM_MEMBER = 5;

    // Reset values.
    localparam logic [7:0] CTRL_FIRST_RST = 8'h00;
    localparam logic [4:0] MEMBER_RST = 5'h00;
    localparam logic [2:0] RTC_SEL_RST = 3'h0;

    // Vector addresses handed to the sequencer.
    localparam logic [7:0] VEC_TIMER_ZERO = 8'h0c;
    localparam logic [7:0] VEC_TIMER_ONE = 8'h10;
    localparam logic [7:0] VEC_SERIAL = 8'h14;
    localparam logic [7:0] VEC_SHARED = 8'h18;

    // Divider figures for the fs clock, the rtc and the time base.
    localparam logic [1:0] FS_SRC_XTAL = 2'h0;
    localparam logic [1:0] FS_SRC_INTERNAL = 2'h1;
    localparam logic [1:0] FS_SRC_SYS = 2'h2;
    localparam int SYS_DIV = 4;
    localparam logic [1:0] SYS_DIV_LAST = 2'(SYS_DIV - 1);
    localparam int RTC_EXP_MAX = 15;
    localparam logic [2:0] RTC_SEL_MAX = 3'h7;
    localparam logic [1:0] TICK_SEL_MAX = 2'h3;
    localparam logic [14:0] FULL_MASK = 15'h7fff;

endpackage

// [rtl/fs_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none

module fs_tick_gen
    import irq_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] fs_src_i,
    input wire logic xtal_tick_i,
    input wire logic internal_slow_oscillator_i,
    input wire logic [2:0] rtc_sel_i,
    input wire logic [1:0] tick_sel_i,
    output logic rtc_ovf_o,
    output logic tick_ovf_o
);

    logic [1:0] sys_div_q;
    logic [RTC_EXP_MAX-1:0] cnt_q;
    logic rtc_ovf_q;
    logic tick_ovf_q;

    // The fs enable comes from one of three sources picked by a strap.
    wire sys_quarter = (sys_div_q == SYS_DIV_LAST);
    wire fs_pulse = (fs_src_i == FS_SRC_XTAL) ? xtal_tick_i : // R12
                    (fs_src_i == FS_SRC_INTERNAL) ? internal_slow_oscillator_i :
                    (fs_src_i == FS_SRC_SYS) ? sys_quarter : 1'b0;

    // A period of 2^n fs cycles ends when the low n counter bits are all ones.
    wire [14:0] rtc_mask = FULL_MASK >> (RTC_SEL_MAX - rtc_sel_i); // R11
    wire [14:0] tick_mask = FULL_MASK >> (TICK_SEL_MAX - tick_sel_i); // R14
    wire rtc_wrap = fs_pulse & (&(cnt_q | ~rtc_mask));
    wire tick_wrap = fs_pulse & (&(cnt_q | ~tick_mask));

    // One free counter serves both dividers, so changing the rtc ratio may
    // shorten the current period but never stalls it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sys_div_q <= 2'h0;
            cnt_q <= 15'h0000;
            rtc_ovf_q <= 1'b0;
            tick_ovf_q <= 1'b0;
        end
        else
        begin
            sys_div_q <= sys_div_q + 2'h1;
            cnt_q <= cnt_q + {14'h0000, fs_pulse};
            rtc_ovf_q <= rtc_wrap;
            tick_ovf_q <= tick_wrap;
        end
    end

    assign rtc_ovf_o = rtc_ovf_q;
    assign tick_ovf_o = tick_ovf_q;

    // Each overflow pulse follows an fs pulse.
    a_rtc_from_fs: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        rtc_ovf_o |-> $past(fs_pulse))
        else $error("rtc overflow without fs pulse");

endmodule

`default_nettype wire

// [rtl/irq_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

// Function
// R1 - Timer overflows set flags; need global+own enable.
// R2 - Timer zero vectors 0CH, timer one own.
// R3 - Timer service clears its flag and global.
// R4 - Timer two flag feeds shared vector.
// R5 - Any member sets shared flag; vectors 018H.
// R6 - Shared service clears only shared flag, global.
// R7 - Converter done flag joins shared when enabled.
// R8 - Serial byte or address match; vector 14H.
// R9 - Serial service clears its flag and global.
// R10 - Rtc overflow flag joins shared when enabled.
// R11 - Rtc period 2^8..2^15 fs by field.
// R12 - Fs from crystal, internal oscillator, sys/4.
// R13 - Time base flag joins shared when enabled.
// R14 - Time base period 2^12..2^15 fs, strapped.
// R15 - Flags stay set until serviced or cleared.
// R16 - No acknowledge while return stack full.
// R17 - Every source can wake from power-down.
// R18 - Accepting pushes only the program counter.
// R19 - Fixed priority: timers, serial, then shared.
// R20 - Cleared global enable blocks every source.
// R21 - Hardware clear of shared flag beats software.
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Source events, one-cycle pulses.
    input wire logic timer_zero_ovf_i,
    input wire logic timer_one_ovf_i,
    input wire logic timer_two_ovf_i,
    input wire logic converter_done_i,
    input wire logic serial_byte_done_i,
    input wire logic serial_addr_match_i,
    input wire logic periph_irq_i,
    // Configuration straps and fs sources.
    input wire logic [1:0] fs_src_i,
    input wire logic [1:0] tick_sel_i,
    input wire logic xtal_tick_i,
    input wire logic internal_slow_oscillator_i,
    // Sequencer and stack.
    input wire logic stack_full_i,
    input wire logic irq_take_i,
    output logic irq_req_o,
    output logic [7:0] irq_vector_o,
    output logic push_pc_o,
    output logic wake_o
);

    logic global_irq_enable_q;
    logic [NUM_DIRECT-1:0] direct_en_q;
    logic shared_vector_enable_q;
    logic [NUM_DIRECT-1:0] direct_req_q;
    logic shared_vector_request_q;
    logic [NUM_MEMBER-1:0] member_en_q;
    logic [NUM_MEMBER-1:0] member_req_q;
    logic [2:0] rtc_divider_control_q;
    logic pend_q;
    logic [7:0] vec_q;
    logic wake_q;
    logic ack_q;
    logic [31:0] rd_q;
    logic rtc_ovf;
    logic tick_ovf;

    // Bus decode; a write lands on the edge where the master sees ack.
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire wr_now = bus_req & wb_we_i & ack_q;
    wire hit_first = (wb_adr_i == OFS_CTRL_FIRST);
    wire hit_second = (wb_adr_i == OFS_CTRL_SECOND);
    wire hit_shared = (wb_adr_i == OFS_SHARED_CTRL);
    wire hit_rtc = (wb_adr_i == OFS_RTC_CTRL);
    wire hit_status = (wb_adr_i == OFS_STATUS);
    wire wr_first = wr_now & hit_first & wb_sel_i[0];
    wire wr_second = wr_now & hit_second & wb_sel_i[0];
    wire wr_member_en = wr_now & hit_shared & wb_sel_i[0];
    wire wr_member_req = wr_now & hit_shared & wb_sel_i[1];
    wire wr_rtc = wr_now & hit_rtc & wb_sel_i[0];

    // Tick generator for the rtc and the time base.
    fs_tick_gen u_ticks (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fs_src_i(fs_src_i),
        .xtal_tick_i(xtal_tick_i),
        .internal_slow_oscillator_i(internal_slow_oscillator_i),
        .rtc_sel_i(rtc_divider_control_q),
        .tick_sel_i(tick_sel_i),
        .rtc_ovf_o(rtc_ovf),
        .tick_ovf_o(tick_ovf)
    );

    // Event vectors; direct order is timer zero, timer one, serial.
    wire [NUM_DIRECT-1:0] direct_evt = {serial_byte_done_i | serial_addr_match_i, // R8
                                        timer_one_ovf_i, timer_zero_ovf_i}; // R1
    wire [NUM_MEMBER-1:0] member_evt = {periph_irq_i, timer_two_ovf_i, // R4
                                        tick_ovf, rtc_ovf, converter_done_i}; // R7 R10 R13
    wire any_member_evt = |member_evt;

    // Serviceable sources under every enable level.
    wire [NUM_DIRECT-1:0] direct_serv = direct_req_q & direct_en_q
                                        & {NUM_DIRECT{global_irq_enable_q}}; // R1 R20
    wire member_live = |(member_req_q & member_en_q); // R7 R10 R13
    wire shared_serv = global_irq_enable_q & shared_vector_enable_q
                       & shared_vector_request_q & member_live; // R5 R20

    // Fixed priority pick of the next vector.
    wire [7:0] vec_d = direct_serv[0] ? VEC_TIMER_ZERO : // R19 R2
                       direct_serv[1] ? VEC_TIMER_ONE :
                       direct_serv[2] ? VEC_SERIAL :
                       VEC_SHARED;
    wire pend_d = (|direct_serv) | shared_serv;

    // Handshake: a full stack withholds the request until an entry frees.
    wire accept = irq_req_o & irq_take_i;
    assign irq_req_o = pend_q & ~stack_full_i; // R16
    assign push_pc_o = accept; // R18
    wire svc_t0 = accept & (vec_q == VEC_TIMER_ZERO);
    wire svc_t1 = accept & (vec_q == VEC_TIMER_ONE);
    wire svc_serial = accept & (vec_q == VEC_SERIAL);
    wire svc_shared = accept & (vec_q == VEC_SHARED);
    wire [NUM_DIRECT-1:0] direct_clr = {svc_serial, svc_t1, svc_t0}; // R3 R9

    // Software reads; unmapped offsets answer zero.
    wire [7:0] first_word = {direct_req_q, shared_vector_enable_q, direct_en_q,
                             global_irq_enable_q};
    wire [31:0] rd_d = hit_first ? {24'h000000, first_word} :
                       hit_second ? {31'h00000000, shared_vector_request_q} :
                       hit_shared ? {19'h00000, member_req_q, 3'h0, member_en_q} :
                       hit_rtc ? {29'h00000000, rtc_divider_control_q} :
                       hit_status ? {22'h000000, stack_full_i, pend_q, vec_q} :
                       32'h00000000;

    // Bus answer: one wait cycle, then ack for one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rd_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= bus_req & ~ack_q;
            rd_q <= rd_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;

    // Global enable: service clears it and beats a same-cycle software set.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            global_irq_enable_q <= CTRL_FIRST_RST[GLOBAL_EN_BIT];
        else if (accept)
            global_irq_enable_q <= 1'b0; // R3 R9 R6
        else if (wr_first)
            global_irq_enable_q <= wb_dat_i[GLOBAL_EN_BIT];
    end

    // Plain software enables and the rtc ratio field.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            direct_en_q <= CTRL_FIRST_RST[DIRECT_EN_LSB +: NUM_DIRECT];
            shared_vector_enable_q <= CTRL_FIRST_RST[SHARED_EN_BIT];
            member_en_q <= MEMBER_RST;
            rtc_divider_control_q <= RTC_SEL_RST;
        end
        else
        begin
            if (wr_first)
            begin
                direct_en_q <= wb_dat_i[DIRECT_EN_LSB +: NUM_DIRECT];
                shared_vector_enable_q <= wb_dat_i[SHARED_EN_BIT];
            end
            if (wr_member_en)
                member_en_q <= wb_dat_i[MEMBER_EN_LSB +: NUM_MEMBER];
            if (wr_rtc)
                rtc_divider_control_q <= wb_dat_i[2:0]; // R11
        end
    end

    // Sticky request flags; a hardware event always beats any clear.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DIRECT; gi++)
        begin : g_direct
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    direct_req_q[gi] <= 1'b0;
                else if (direct_evt[gi])
                    direct_req_q[gi] <= 1'b1; // R1 R8
                else if (direct_clr[gi])
                    direct_req_q[gi] <= 1'b0; // R3 R9
                else if (wr_first)
                    direct_req_q[gi] <= wb_dat_i[DIRECT_REQ_LSB + gi]; // R15
            end
        end
        for (gi = 0; gi < NUM_MEMBER; gi++)
        begin : g_member
            // Member flags are never touched by service; software clears them.
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    member_req_q[gi] <= 1'b0;
                else if (member_evt[gi])
                    member_req_q[gi] <= 1'b1; // R4 R7 R10 R13
                else if (wr_member_req)
                    member_req_q[gi] <= wb_dat_i[MEMBER_REQ_LSB + gi]; // R6 R15
            end
        end
    endgenerate

    // Shared flag: a service clear wins over a same-cycle software write.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            shared_vector_request_q <= 1'b0;
        else if (any_member_evt)
            shared_vector_request_q <= 1'b1; // R5
        else if (svc_shared)
            shared_vector_request_q <= 1'b0; // R6 R21
        else if (wr_second)
            shared_vector_request_q <= wb_dat_i[0]; // R15
    end

    // Pending snapshot, vector and wake; the accept term stops a double service
    // in the cycle before the cleared flags show up.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_q <= 1'b0;
            vec_q <= VEC_SHARED;
            wake_q <= 1'b0;
        end
        else
        begin
            pend_q <= pend_d & ~accept; // R20
            vec_q <= vec_d; // R19
            wake_q <= (|(direct_req_q & direct_en_q)) | member_live; // R17
        end
    end

    assign irq_vector_o = vec_q;
    assign wake_o = wake_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take_shared;
        accept && vec_q == VEC_SHARED && !wr_member_req;
    endsequence

    a_service_clears_global: assert property (accept |=> !global_irq_enable_q) // R3
        else $error("global enable survived a service");
    a_timer_zero_cleared: assert property (svc_t0 && !timer_zero_ovf_i |=> !direct_req_q[0]) // R3
        else $error("timer zero flag not cleared on service");
    a_serial_cleared: assert property (svc_serial && !direct_evt[2] |=> !direct_req_q[2]) // R9
        else $error("serial flag not cleared on service");
    a_stack_full_blocks: assert property (stack_full_i |-> !irq_req_o) // R16
        else $error("request offered with full stack");
    a_global_gates_all: assert property (!global_irq_enable_q |=> !pend_q) // R20
        else $error("pending while global enable clear");
    a_members_kept: assert property (s_take_shared |=> // R6
        (member_req_q & $past(member_req_q)) == $past(member_req_q))
        else $error("member flag lost on shared service");
    a_flag_sticky: assert property ( // R15
        direct_req_q[1] && !svc_t1 && !wr_first |=> direct_req_q[1])
        else $error("timer one flag dropped without clear");
    a_overflow_sets: assert property (timer_one_ovf_i |=> direct_req_q[1]) // R1
        else $error("timer one overflow not recorded");
    a_member_sets_shared: assert property (any_member_evt |=> shared_vector_request_q) // R5
        else $error("shared flag not set by member");
    a_timer_zero_first: assert property ( // R19
        direct_serv[0] && !accept |=> vec_q == VEC_TIMER_ZERO)
        else $error("timer zero lost priority");
    a_wake_follows: assert property (direct_req_q[2] && direct_en_q[2] |=> wake_o) // R17
        else $error("enabled request did not wake");

    // A shared service with no member event in the same cycle.
    sequence s_take_quiet;
        svc_shared && !any_member_evt;
    endsequence

    // A serviceable direct source held back by a full stack.
    sequence s_blocked;
        stack_full_i && (|direct_serv);
    endsequence

    // Vector order below timer zero; a broken mux order trips these.
    a_timer_one_vector: assert property ( // R2
        direct_serv[1] && !direct_serv[0] |=> irq_vector_o == VEC_TIMER_ONE)
        else $error("timer one vector wrong");
    a_serial_vector: assert property ( // R8
        direct_serv[2] && !direct_serv[1] && !direct_serv[0] |=> irq_vector_o == VEC_SERIAL)
        else $error("serial vector wrong");
    a_shared_vector: assert property ( // R5
        shared_serv && !(|direct_serv) |=> irq_vector_o == VEC_SHARED)
        else $error("shared vector wrong");

    // Only one stack push per accepted request.
    a_single_push: assert property ( // R18
        push_pc_o |=> !push_pc_o)
        else $error("second push for one service");

    // Each member event except the peripheral one, and the address match, lands in its own flag.
    a_timer_two_sets: assert property ( // R4
        timer_two_ovf_i |=> member_req_q[3] && shared_vector_request_q)
        else $error("timer two overflow not recorded");
    a_converter_sets: assert property ( // R7
        converter_done_i |=> member_req_q[0])
        else $error("converter done not recorded");
    a_rtc_sets: assert property ( // R10
        rtc_ovf |=> member_req_q[1])
        else $error("rtc overflow not recorded");
    a_tick_sets: assert property ( // R13
        tick_ovf |=> member_req_q[2])
        else $error("time base overflow not recorded");
    a_match_sets: assert property ( // R8
        serial_addr_match_i |=> direct_req_q[2])
        else $error("address match not recorded");

    // The service clear of the shared flag wins over a software write.
    a_shared_cleared: assert property ( // R21
        s_take_quiet |=> !shared_vector_request_q)
        else $error("shared flag survived its service");

    // Without an enabled member flag the shared source stays quiet.
    a_member_gates: assert property ( // R7
        !(|direct_serv) && !member_live |=> !pend_q)
        else $error("pending without enabled source");
    a_wake_member: assert property ( // R17
        member_live |=> wake_o)
        else $error("enabled member did not wake");

    // A request held off by a full stack is kept, not dropped.
    a_full_holds: assert property ( // R16
        s_blocked |=> pend_q)
        else $error("blocked request lost while stack full");

endmodule

`default_nettype wire

// [tb/seq_model.sv]
`timescale 1ns/1ps
`default_nettype none

module seq_model #(
    parameter int DEPTH = 2
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic slow_i,
    output logic take_o,
    output logic full_o,
    output logic [3:0] depth_o
);
    logic [3:0] sp_q;
    logic [1:0] wait_q;

    // A slow sequencer lets a request stand three cycles, so a request must hold.
    assign take_o = req_i & (~slow_i | (wait_q == 2'h3));
    assign full_o = (sp_q == 4'(DEPTH));
    assign depth_o = sp_q;

    // One stack entry per accept, since only the program counter is saved.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sp_q <= 4'h0;
        else if (push_i && !pop_i)
            sp_q <= sp_q + 4'h1;
        else if (pop_i && !push_i && sp_q != 4'h0)
            sp_q <= sp_q - 4'h1;
    end

    // Counts how long the offered request has stood.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !req_i)
            wait_q <= 2'h0;
        else if (wait_q != 2'h3)
            wait_q <= wait_q + 2'h1;
    end
endmodule

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_top import irq_ctrl_pkg::*;;
    logic clk_i, rst_i, cyc, stb, we, slow, pop, xtal, slow_osc;
    logic [7:0] adr;
    logic [31:0] dat, rdat, wb_dat_o;
    logic [6:0] ev;
    logic [1:0] fs_src, tick_sel;
    logic wb_ack_o, irq_req_o, push_pc_o, wake_o, take, full;
    logic [7:0] irq_vector_o, f;
    logic [3:0] depth;
    int fail_count, checks, cyc_n, t;
    int dsrc [4] = '{0, 1, 2, 2};
    logic [7:0] dvec [4] = '{VEC_TIMER_ZERO, VEC_TIMER_ONE, VEC_SERIAL, VEC_SERIAL};
    int mbit [3] = '{0, 3, 4};
    int tbl [6][5] = '{'{1, 0, 0, 1, 256}, '{1, 3, 0, 1, 2048}, '{2, 1, 0, 1, 2048},
        '{0, 0, 0, 1, 512}, '{1, 0, 0, 2, 4096}, '{1, 0, 1, 2, 8192}};

    irq_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .timer_zero_ovf_i(ev[0]), .timer_one_ovf_i(ev[1]),
        .serial_byte_done_i(ev[2]), .serial_addr_match_i(ev[3]), .converter_done_i(ev[4]),
        .timer_two_ovf_i(ev[5]), .periph_irq_i(ev[6]), .fs_src_i(fs_src),
        .tick_sel_i(tick_sel), .xtal_tick_i(xtal), .internal_slow_oscillator_i(slow_osc),
        .stack_full_i(full), .irq_take_i(take), .irq_req_o(irq_req_o),
        .irq_vector_o(irq_vector_o), .push_pc_o(push_pc_o), .wake_o(wake_o));

    seq_model #(.DEPTH(2)) seq_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(irq_req_o),
        .push_i(push_pc_o), .pop_i(pop), .slow_i(slow), .take_o(take), .full_o(full),
        .depth_o(depth));

    // Clock, cycle count and a crystal tick at half the system rate.
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc_n <= cyc_n + 1;
    end

    // The crystal tick follows the cycle count, so it has a single driver.
    assign xtal = cyc_n[0];

    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One classic Wishbone access; the request holds until ack is sampled.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        rdat = wb_dat_o;
        if (n >= 20)
            fail_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK("read", e, rdat)
    endtask

    task automatic pulse(input logic [6:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 7'h0;
    endtask

    // Waits for an accept, checks its vector, then optionally frees the stack entry.
    task automatic service(input logic [7:0] v, input logic dp);
        int n;
        n = 0;
        @(negedge clk_i);
        while (push_pc_o !== 1'b1 && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
        `CHK("accept", 1'b1, push_pc_o)
        `CHK("vector", v, irq_vector_o)
        @(negedge clk_i);
        `CHK("req after accept", 1'b0, irq_req_o)
        if (dp)
        begin
            @(posedge clk_i);
            pop <= 1'b1;
            @(posedge clk_i);
            pop <= 1'b0;
        end
    endtask

    task automatic wait_wake();
        int n;
        n = 0;
        @(negedge clk_i);
        while (wake_o !== 1'b1 && n < 70000)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 70000)
            fail_count++;
    endtask

    // Watchdog sized well above the roughly 28000 cycles the tests need.
    initial
    begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        end_sim();
    end

    initial
    begin
        {rst_i, cyc, stb, we, slow, pop, slow_osc} = 7'h41;
        {adr, dat, ev, tick_sel} = '0;
        fs_src = 2'h3;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 16; k += 4)
            rd_chk(8'(k), 32'h0);
        rd_chk(OFS_STATUS, 32'h18);
        xfer(1'b1, 8'h20, 32'hff);
        rd_chk(8'h20, 32'h0);
        rd_chk(OFS_CTRL_FIRST, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            xfer(1'b1, OFS_CTRL_FIRST, 32'(8'h01 | (8'h02 << dsrc[k])));
            pulse(7'(1 << k));
            service(dvec[k], 1'b1);
            rd_chk(OFS_CTRL_FIRST, 32'(8'h02 << dsrc[k]));
        end
        $display("test direct done");
        xfer(1'b1, OFS_CTRL_FIRST, 32'h0e);
        pulse(7'h07);
        repeat (4) @(negedge clk_i);
        `CHK("no global", 1'b0, irq_req_o)
        `CHK("wake", 1'b1, wake_o)
        rd_chk(OFS_CTRL_FIRST, 32'hee);
        slow <= 1'b1;
        f = 8'he0;
        for (int k = 0; k < 3; k++)
        begin
            xfer(1'b1, OFS_CTRL_FIRST, 32'(f | 8'h0f));
            service(dvec[k], 1'b1);
            f = f & ~(8'h20 << k);
            rd_chk(OFS_CTRL_FIRST, 32'(f | 8'h0e));
        end
        slow <= 1'b0;
        $display("test priority done");
        for (int k = 0; k < 3; k++)
        begin
            xfer(1'b1, OFS_CTRL_FIRST, 32'h03);
            pulse(7'h01);
            if (k < 2)
                service(VEC_TIMER_ZERO, 1'b0);
        end
        repeat (6) @(negedge clk_i);
        `CHK("stack full", 1'b0, irq_req_o)
        `CHK("depth", 4'h2, depth)
        rd_chk(OFS_STATUS, 32'h30c);
        @(posedge clk_i);
        pop <= 1'b1;
        @(posedge clk_i);
        pop <= 1'b0;
        service(VEC_TIMER_ZERO, 1'b1);
        $display("test stack done");
        xfer(1'b1, OFS_SHARED_CTRL, 32'h0);
        xfer(1'b1, OFS_CTRL_FIRST, 32'h11);
        pulse(7'h10);
        repeat (4) @(negedge clk_i);
        `CHK("no member en", 1'b0, irq_req_o)
        rd_chk(OFS_CTRL_SECOND, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            xfer(1'b1, OFS_SHARED_CTRL, 32'(1 << mbit[k]));
            xfer(1'b1, OFS_CTRL_FIRST, 32'h11);
            pulse(7'(8'h10 << k));
            service(VEC_SHARED, 1'b1);
            rd_chk(OFS_CTRL_SECOND, 32'h0);
            rd_chk(OFS_SHARED_CTRL, 32'((1 << mbit[k]) | (1 << (8 + mbit[k]))));
            rd_chk(OFS_CTRL_FIRST, 32'h10);
        end
        $display("test shared done");
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk_i);
            fs_src <= 2'(tbl[k][0]);
            tick_sel <= 2'(tbl[k][2]);
            xfer(1'b1, OFS_RTC_CTRL, 32'(tbl[k][1]));
            xfer(1'b1, OFS_SHARED_CTRL, 32'(1 << tbl[k][3]));
            repeat (3) @(negedge clk_i);
            wait_wake();
            t = cyc_n;
            xfer(1'b1, OFS_SHARED_CTRL, 32'(1 << tbl[k][3]));
            repeat (3) @(negedge clk_i);
            wait_wake();
            `CHK("period", tbl[k][4], cyc_n - t)
        end
        $display("test periods done");
        end_sim();
    end
endmodule

`default_nettype wire
